// ==== hw/asqr_defs.vh ====
// Shared constants of the axis status query responder
`ifndef ASQR_DEFS_VH
`define ASQR_DEFS_VH

`define ASQR_AXES          4
`define ASQR_AX_W          2
`define ASQR_LAST_AXIS     2'h3
`define ASQR_LANE_W        32
`define ASQR_BUS_W         128
`define ASQR_ADDR_W        8
`define ASQR_DATA_W        32

// Register byte addresses
`define ASQR_CTRL_ADDR     8'h00
`define ASQR_CMD_ADDR      8'h04
`define ASQR_STAT_ADDR     8'h08
`define ASQR_DATA_ADDR     8'h0c

// Control register fields and reset value
`define ASQR_CTRL_ALL      0
`define ASQR_CTRL_SEL_LO   1
`define ASQR_CTRL_SEL_HI   2
`define ASQR_CTRL_RESET    3'h0

// Status register fields
`define ASQR_ST_BUSY       0
`define ASQR_ST_AVAIL      1
`define ASQR_ST_REJECT     2
`define ASQR_ST_CNT_LO     8
`define ASQR_ST_DONE_LO    16
`define ASQR_ST_LIMIT      20

// Command codes, low nibble of a command write
`define ASQR_OP_W          4
`define ASQR_OP_NONE       4'h0
`define ASQR_OP_AXIS_CLR   4'h1
`define ASQR_OP_ALL_CLR    4'h2
`define ASQR_OP_AXIS_QRY   4'h3
`define ASQR_OP_ALL_QRY    4'h4
`define ASQR_OP_ACCEL      4'h5
`define ASQR_OP_VEL        4'h6
`define ASQR_OP_UPOS       4'h7
`define ASQR_OP_DONE_CLR   4'h8

// Reply characters
`define ASQR_CH_LF         8'h0a
`define ASQR_CH_CR         8'h0d
`define ASQR_CH_COMMA      8'h2c
`define ASQR_CH_MINUS      8'h2d
`define ASQR_CH_DOT        8'h2e
`define ASQR_CH_ZERO       8'h30
`define ASQR_CH_P          8'h50
`define ASQR_CH_M          8'h4d
`define ASQR_CH_D          8'h44
`define ASQR_CH_N          8'h4e
`define ASQR_CH_L          8'h4c
`define ASQR_CH_H          8'h48

// Reply layout
`define ASQR_CIDX_W        2
`define ASQR_FLD_DIR       2'h0
`define ASQR_FLD_DONE      2'h1
`define ASQR_FLD_LIMIT     2'h2
`define ASQR_FLD_HOME      2'h3
`define ASQR_FRAME_STAT    2'h2
`define ASQR_FRAME_NUM     2'h1

// Number formatting
`define ASQR_VEL_FRAC      8
`define ASQR_VEL_HALF      33'h000000080
`define ASQR_DIGITS        10
`define ASQR_DIG_W         4
`define ASQR_DI_W          4
`define ASQR_BCD_W         40
`define ASQR_BCD_STEPS     6'h20
`define ASQR_INT_MIN_IDX   4'h0
`define ASQR_POS_MIN_IDX   4'h5
`define ASQR_POS_DOT_IDX   4'h4

// Reply buffer
`define ASQR_MEM_DEPTH     64
`define ASQR_PTR_W         6

`endif

// ==== hw/asqr_reply_mem.v ====
// Reply character buffer with registered read data
`timescale 1ns/1ps
`include "asqr_defs.vh"

module asqr_reply_mem (
    input  wire                    pclk,
    input  wire                    wr_en,
    input  wire [`ASQR_PTR_W-1:0]  wr_addr,
    input  wire [7:0]              wr_data,
    input  wire [`ASQR_PTR_W-1:0]  rd_addr,
    output reg  [7:0]              rd_data
);

reg [7:0] store [0:`ASQR_MEM_DEPTH-1];

always @(posedge pclk) begin
    if (wr_en) begin
        store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
end

endmodule // asqr_reply_mem

// ==== hw/asqr_bcd.v ====
// Sequential binary to decimal converter, one bit per cycle
`timescale 1ns/1ps
`include "asqr_defs.vh"

module asqr_bcd (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    start,
    input  wire [`ASQR_LANE_W-1:0] value,
    output reg                     done,
    output reg  [`ASQR_BCD_W-1:0]  bcd
);

reg [`ASQR_LANE_W-1:0] shift;
reg [5:0]              count;
reg                    active;
reg [`ASQR_BCD_W-1:0]  adj;
integer                i;

// Add three to digits above four
always @* begin
    adj = bcd;
    for (i = 0; i < `ASQR_DIGITS; i = i + 1) begin
        if (adj[i*`ASQR_DIG_W +: `ASQR_DIG_W] > 4'h4) begin
            adj[i*`ASQR_DIG_W +: `ASQR_DIG_W] = adj[i*`ASQR_DIG_W +: `ASQR_DIG_W] + 4'h3;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        shift  <= {`ASQR_LANE_W{1'b0}};
        count  <= 6'h0;
        active <= 1'b0;
        done   <= 1'b0;
        bcd    <= {`ASQR_BCD_W{1'b0}};
    end else begin
        done <= 1'b0;
        if (start) begin
            shift  <= value;
            bcd    <= {`ASQR_BCD_W{1'b0}};
            count  <= `ASQR_BCD_STEPS;
            active <= 1'b1;
        end else if (active) begin
            bcd   <= {adj[`ASQR_BCD_W-2:0], shift[`ASQR_LANE_W-1]};
            shift <= {shift[`ASQR_LANE_W-2:0], 1'b0};
            count <= count - 6'h1;
            if (count == 6'h1) begin
                active <= 1'b0;
                done   <= 1'b1;
            end
        end
    end
end

endmodule // asqr_bcd

// ==== hw/asqr_top.v ====
// Axis status and query responder with APB register access
//
// Notes on behaviour
// RULE1: Axis status gives limit, home, done, direction of selected axis.
// RULE2: Axis status clears limit flag unless another axis in limit.
// RULE3: Axis status clears done flag.
// RULE4: Status reply: LF CR CR, four chars, LF CR CR.
// RULE5: Char 4: P positive, M negative.
// RULE6: Char 5: D after done notify, else N.
// RULE7: Char 6: L in limit, else N.
// RULE8: Char 7: H at home, else N.
// RULE9: All-axes status: fields comma separated, same framing.
// RULE10: All-axes status clears done flags.
// RULE11: Axis query: same reply, flags kept.
// RULE12: All-axes query: all fields, flags kept.
// RULE13: Accel: start when stopped, end at speed, else present.
// RULE14: Contour: accel gives lead-in value.
// RULE15: Accel framed by LF CR, comma separated.
// RULE16: Velocity gives present value, framed by LF CR.
// RULE17: Fractional jog: velocity integer part only.
// RULE18: Position: five fractional digits, framed.
// RULE19: Axis status, query, position only in single-axis mode.
// RULE20: Mode-invalid command ignored: no reply, no flag change.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "asqr_defs.vh"

module asqr_top (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire [`ASQR_ADDR_W-1:0] paddr,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`ASQR_DATA_W-1:0] pwdata,
    output reg  [`ASQR_DATA_W-1:0] prdata,
    output reg                     pready,
    output reg                     pslverr,
    input  wire [`ASQR_AXES-1:0]   limit_pin,
    input  wire [`ASQR_AXES-1:0]   home_pin,
    input  wire [`ASQR_AXES-1:0]   axis_dir_neg,
    input  wire [`ASQR_AXES-1:0]   done_notify,
    input  wire [`ASQR_AXES-1:0]   axis_stopped,
    input  wire [`ASQR_AXES-1:0]   axis_at_speed,
    input  wire                    contour_active,
    input  wire                    fractional_jog,
    input  wire [`ASQR_BUS_W-1:0]  accel_start,
    input  wire [`ASQR_BUS_W-1:0]  accel_end,
    input  wire [`ASQR_BUS_W-1:0]  accel_now,
    input  wire [`ASQR_BUS_W-1:0]  accel_lead_in,
    input  wire [`ASQR_BUS_W-1:0]  velocity,
    input  wire [`ASQR_BUS_W-1:0]  user_position,
    output reg  [`ASQR_AXES-1:0]   done_flags,
    output reg                     limit_flag
);

localparam S_IDLE = 7'b0000001;
localparam S_HEAD = 7'b0000010;
localparam S_ITEM = 7'b0000100;
localparam S_CONV = 7'b0001000;
localparam S_NUM  = 7'b0010000;
localparam S_SEP  = 7'b0100000;
localparam S_TAIL = 7'b1000000;

reg  [6:0]                state;
reg  [`ASQR_OP_W-1:0]     op;
reg  [`ASQR_AX_W-1:0]     ax;
reg                       multi;
reg  [`ASQR_CIDX_W-1:0]   cidx;
reg  [`ASQR_DI_W-1:0]     di;
reg                       dot_done;
reg                       neg_q;
reg                       fmt_start;
reg  [`ASQR_LANE_W-1:0]   fmt_value;
reg                       mem_we;
reg  [`ASQR_PTR_W-1:0]    mem_waddr;
reg  [7:0]                mem_wdata;
reg  [`ASQR_PTR_W-1:0]    wr_ptr;
reg  [`ASQR_PTR_W-1:0]    rd_ptr;
reg  [`ASQR_AXES-1:0]     snap_done;
reg  [2:0]                ctrl;
reg                       rejected;
reg  [`ASQR_AXES-1:0]     lim_s1;
reg  [`ASQR_AXES-1:0]     lim_s2;
reg  [`ASQR_AXES-1:0]     lim_d;
reg  [`ASQR_AXES-1:0]     home_s1;
reg  [`ASQR_AXES-1:0]     home_s2;
wire                      fmt_done;
wire [`ASQR_BCD_W-1:0]    fmt_bcd;
wire [7:0]                mem_rdata;

wire                      all_mode = ctrl[`ASQR_CTRL_ALL];
wire [`ASQR_AX_W-1:0]     axis_sel = ctrl[`ASQR_CTRL_SEL_HI:`ASQR_CTRL_SEL_LO];
wire                      busy     = ~state[0];
wire                      avail    = ~busy & (rd_ptr != wr_ptr);
wire                      is_stat  = (op == `ASQR_OP_AXIS_CLR) | (op == `ASQR_OP_ALL_CLR) |
                                     (op == `ASQR_OP_AXIS_QRY) | (op == `ASQR_OP_ALL_QRY);
wire                      is_pos   = (op == `ASQR_OP_UPOS);
wire [`ASQR_CIDX_W-1:0]   frame_last = is_stat ? `ASQR_FRAME_STAT : `ASQR_FRAME_NUM;
wire                      apb_acc  = psel & penable;
wire                      apb_end  = apb_acc & pready;
wire [`ASQR_OP_W-1:0]     cmd_code = pwdata[`ASQR_OP_W-1:0];
wire                      cmd_wr   = apb_end & pwrite & (paddr == `ASQR_CMD_ADDR);
wire                      pop      = apb_end & ~pwrite & (paddr == `ASQR_DATA_ADDR) & avail;

function [`ASQR_LANE_W-1:0] lane;
    input [`ASQR_BUS_W-1:0] v;
    input [`ASQR_AX_W-1:0]  a;
    begin
        lane = v[a*`ASQR_LANE_W +: `ASQR_LANE_W];
    end
endfunction

function [`ASQR_AXES-1:0] onehot;
    input [`ASQR_AX_W-1:0] a;
    begin
        onehot = {{(`ASQR_AXES-1){1'b0}}, 1'b1} << a;
    end
endfunction

function [7:0] field_char;
    input [`ASQR_CIDX_W-1:0] idx;
    input                    neg;
    input                    dn;
    input                    lim;
    input                    home;
    begin
        case (idx)
            `ASQR_FLD_DIR:   field_char = neg ? `ASQR_CH_M : `ASQR_CH_P;   // see RULE5
            `ASQR_FLD_DONE:  field_char = dn ? `ASQR_CH_D : `ASQR_CH_N;    // see RULE6
            `ASQR_FLD_LIMIT: field_char = lim ? `ASQR_CH_L : `ASQR_CH_N;   // see RULE7
            default:         field_char = home ? `ASQR_CH_H : `ASQR_CH_N;  // see RULE8
        endcase
    end
endfunction

// Highest non-zero digit, at least min_idx
function [`ASQR_DI_W-1:0] first_digit;
    input [`ASQR_BCD_W-1:0] b;
    input [`ASQR_DI_W-1:0]  min_idx;
    integer                 k;
    begin
        first_digit = min_idx;
        for (k = 0; k < `ASQR_DIGITS; k = k + 1) begin
            if ((b[k*`ASQR_DIG_W +: `ASQR_DIG_W] != 4'h0) && (k > min_idx)) begin
                first_digit = k[`ASQR_DI_W-1:0];
            end
        end
    end
endfunction

// Switch pins are asynchronous to pclk
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lim_s1  <= {`ASQR_AXES{1'b0}};
        lim_s2  <= {`ASQR_AXES{1'b0}};
        lim_d   <= {`ASQR_AXES{1'b0}};
        home_s1 <= {`ASQR_AXES{1'b0}};
        home_s2 <= {`ASQR_AXES{1'b0}};
    end else begin
        lim_s1  <= limit_pin;
        lim_s2  <= lim_s1;
        lim_d   <= lim_s2;
        home_s1 <= home_pin;
        home_s2 <= home_s1;
    end
end

// Command acceptance and mode check
reg mode_ok;
always @* begin
    case (cmd_code)
        `ASQR_OP_AXIS_CLR, `ASQR_OP_AXIS_QRY, `ASQR_OP_UPOS:
            mode_ok = ~all_mode;                                        // see RULE19
        `ASQR_OP_ALL_CLR, `ASQR_OP_ALL_QRY:
            mode_ok = all_mode;
        `ASQR_OP_ACCEL, `ASQR_OP_VEL, `ASQR_OP_DONE_CLR:
            mode_ok = 1'b1;
        default:
            mode_ok = 1'b0;
    endcase
end

wire accept   = cmd_wr & mode_ok & ~busy;                               // see RULE20
wire replying = accept & (cmd_code != `ASQR_OP_DONE_CLR);

// Flag side effects happen only for accepted commands
reg [`ASQR_AXES-1:0] done_clr;
reg                  lim_clr;
always @* begin
    done_clr = {`ASQR_AXES{1'b0}};
    lim_clr  = 1'b0;
    if (accept) begin
        case (cmd_code)
            `ASQR_OP_AXIS_CLR: begin
                done_clr = onehot(axis_sel);                            // see RULE3
                lim_clr  = ((lim_s2 & ~onehot(axis_sel)) == {`ASQR_AXES{1'b0}});  // see RULE2
            end
            `ASQR_OP_ALL_CLR:  done_clr = {`ASQR_AXES{1'b1}};           // see RULE10
            `ASQR_OP_DONE_CLR: done_clr = all_mode ? {`ASQR_AXES{1'b1}} : onehot(axis_sel);
            default:           done_clr = {`ASQR_AXES{1'b0}};
        endcase
    end
end

// A new event wins over a clear in the same cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        done_flags <= {`ASQR_AXES{1'b0}};
        limit_flag <= 1'b0;
    end else begin
        done_flags <= (done_flags & ~done_clr) | done_notify;           // see RULE6
        limit_flag <= (|(lim_s2 & ~lim_d)) | (limit_flag & ~lim_clr);
    end
end

// Value selection for numeric replies
reg [`ASQR_LANE_W-1:0] num_mag;
reg                    num_neg;
reg [`ASQR_LANE_W-1:0] raw;
reg [`ASQR_LANE_W-1:0] mag;
reg [`ASQR_LANE_W:0]   rnd;
always @* begin
    raw     = {`ASQR_LANE_W{1'b0}};
    mag     = {`ASQR_LANE_W{1'b0}};
    rnd     = {(`ASQR_LANE_W+1){1'b0}};
    num_mag = {`ASQR_LANE_W{1'b0}};
    num_neg = 1'b0;
    case (op)
        `ASQR_OP_ACCEL: begin
            if (contour_active) begin
                num_mag = lane(accel_lead_in, ax);                      // see RULE14
            end else if (axis_stopped[ax]) begin
                num_mag = lane(accel_start, ax);                        // see RULE13
            end else if (axis_at_speed[ax]) begin
                num_mag = lane(accel_end, ax);
            end else begin
                num_mag = lane(accel_now, ax);
            end
        end
        `ASQR_OP_VEL: begin
            raw = lane(velocity, ax);                                   // see RULE16
            mag = raw[`ASQR_LANE_W-1] ? -raw : raw;
            if (fractional_jog) begin
                rnd = {1'b0, mag} >> `ASQR_VEL_FRAC;                    // see RULE17
            end else begin
                rnd = ({1'b0, mag} + `ASQR_VEL_HALF) >> `ASQR_VEL_FRAC;
            end
            num_mag = rnd[`ASQR_LANE_W-1:0];
            num_neg = raw[`ASQR_LANE_W-1] & (num_mag != {`ASQR_LANE_W{1'b0}});
        end
        `ASQR_OP_UPOS: begin
            raw     = lane(user_position, ax);
            num_mag = raw[`ASQR_LANE_W-1] ? -raw : raw;
            num_neg = raw[`ASQR_LANE_W-1];
        end
        default: num_mag = {`ASQR_LANE_W{1'b0}};
    endcase
end

task emit;
    input [7:0] ch;
    begin
        mem_we    <= 1'b1;
        mem_waddr <= wr_ptr;
        mem_wdata <= ch;
        wr_ptr    <= wr_ptr + {{(`ASQR_PTR_W-1){1'b0}}, 1'b1};
    end
endtask

// Reply builder, at most one character per cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state     <= S_IDLE;
        op        <= `ASQR_OP_NONE;
        ax        <= {`ASQR_AX_W{1'b0}};
        multi     <= 1'b0;
        cidx      <= {`ASQR_CIDX_W{1'b0}};
        di        <= {`ASQR_DI_W{1'b0}};
        dot_done  <= 1'b0;
        neg_q     <= 1'b0;
        fmt_start <= 1'b0;
        fmt_value <= {`ASQR_LANE_W{1'b0}};
        mem_we    <= 1'b0;
        mem_waddr <= {`ASQR_PTR_W{1'b0}};
        mem_wdata <= 8'h00;
        wr_ptr    <= {`ASQR_PTR_W{1'b0}};
        snap_done <= {`ASQR_AXES{1'b0}};
    end else begin
        mem_we    <= 1'b0;
        fmt_start <= 1'b0;
        case (state)
            S_IDLE: begin
                if (replying) begin
                    op        <= cmd_code;
                    multi     <= all_mode;
                    ax        <= all_mode ? {`ASQR_AX_W{1'b0}} : axis_sel;  // see RULE1
                    snap_done <= done_flags;
                    wr_ptr    <= {`ASQR_PTR_W{1'b0}};
                    cidx      <= {`ASQR_CIDX_W{1'b0}};
                    state     <= S_HEAD;
                end
            end
            S_HEAD, S_TAIL: begin
                // Status replies carry LF CR CR, numeric replies LF CR
                emit((cidx == {`ASQR_CIDX_W{1'b0}}) ? `ASQR_CH_LF : `ASQR_CH_CR);  // see RULE4
                if (cidx == frame_last) begin
                    cidx  <= {`ASQR_CIDX_W{1'b0}};
                    state <= (state == S_HEAD) ? S_ITEM : S_IDLE;
                end else begin
                    cidx <= cidx + {{(`ASQR_CIDX_W-1){1'b0}}, 1'b1};
                end
            end
            S_ITEM: begin
                if (is_stat) begin
                    // Snapshot lets a clearing request still show D
                    emit(field_char(cidx, axis_dir_neg[ax], snap_done[ax],
                                    lim_s2[ax], home_s2[ax]));          // see RULE11
                    if (cidx == `ASQR_FLD_HOME) begin
                        cidx  <= {`ASQR_CIDX_W{1'b0}};
                        state <= S_SEP;
                    end else begin
                        cidx <= cidx + {{(`ASQR_CIDX_W-1){1'b0}}, 1'b1};
                    end
                end else begin
                    fmt_start <= 1'b1;
                    fmt_value <= num_mag;
                    neg_q     <= num_neg;
                    state     <= S_CONV;
                end
            end
            S_CONV: begin
                if (fmt_done) begin
                    di       <= first_digit(fmt_bcd, is_pos ? `ASQR_POS_MIN_IDX
                                                            : `ASQR_INT_MIN_IDX);
                    dot_done <= 1'b0;
                    if (neg_q) begin
                        emit(`ASQR_CH_MINUS);
                    end
                    state <= S_NUM;
                end
            end
            S_NUM: begin
                if (is_pos && (di == `ASQR_POS_DOT_IDX) && !dot_done) begin
                    emit(`ASQR_CH_DOT);                                 // see RULE18
                    dot_done <= 1'b1;
                end else begin
                    emit(`ASQR_CH_ZERO + {4'h0, fmt_bcd[di*`ASQR_DIG_W +: `ASQR_DIG_W]});
                    if (di == {`ASQR_DI_W{1'b0}}) begin
                        state <= S_SEP;
                    end else begin
                        di <= di - {{(`ASQR_DI_W-1){1'b0}}, 1'b1};
                    end
                end
            end
            S_SEP: begin
                cidx <= {`ASQR_CIDX_W{1'b0}};
                if (multi && (ax != `ASQR_LAST_AXIS)) begin
                    emit(`ASQR_CH_COMMA);                               // see RULE9
                    ax    <= ax + {{(`ASQR_AX_W-1){1'b0}}, 1'b1};       // see RULE12
                    state <= S_ITEM;
                end else begin
                    state <= S_TAIL;                                    // see RULE15
                end
            end
            default: state <= S_IDLE;
        endcase
    end
end

// APB slave: one wait cycle in every access phase
reg [`ASQR_DATA_W-1:0] rd_value;
reg                    mapped;
always @* begin
    rd_value = {`ASQR_DATA_W{1'b0}};
    mapped   = 1'b1;
    case (paddr)
        `ASQR_CTRL_ADDR: rd_value[2:0] = ctrl;
        `ASQR_CMD_ADDR:  rd_value = {`ASQR_DATA_W{1'b0}};
        `ASQR_STAT_ADDR: begin
            rd_value[`ASQR_ST_BUSY]   = busy;
            rd_value[`ASQR_ST_AVAIL]  = avail;
            rd_value[`ASQR_ST_REJECT] = rejected;
            rd_value[`ASQR_ST_CNT_LO +: `ASQR_PTR_W] = wr_ptr - rd_ptr;
            rd_value[`ASQR_ST_DONE_LO +: `ASQR_AXES] = done_flags;
            rd_value[`ASQR_ST_LIMIT]  = limit_flag;
        end
        `ASQR_DATA_ADDR: rd_value[7:0] = avail ? mem_rdata : 8'h00;
        default:         mapped = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready   <= 1'b0;
        prdata   <= {`ASQR_DATA_W{1'b0}};
        pslverr  <= 1'b0;
        ctrl     <= `ASQR_CTRL_RESET;
        rejected <= 1'b0;
        rd_ptr   <= {`ASQR_PTR_W{1'b0}};
    end else begin
        if (apb_acc && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? {`ASQR_DATA_W{1'b0}} : rd_value;
            pslverr <= ~mapped;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        if (apb_end && pwrite && (paddr == `ASQR_CTRL_ADDR)) begin
            ctrl <= pwdata[2:0];
        end
        if (cmd_wr) begin
            rejected <= ~accept;
        end
        // A new reply discards whatever is left unread
        if (replying) begin
            rd_ptr <= {`ASQR_PTR_W{1'b0}};
        end else if (pop) begin
            rd_ptr <= rd_ptr + {{(`ASQR_PTR_W-1){1'b0}}, 1'b1};
        end
    end
end

asqr_bcd u_bcd (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (fmt_start),
    .value   (fmt_value),
    .done    (fmt_done),
    .bcd     (fmt_bcd)
);

asqr_reply_mem u_mem (
    .pclk    (pclk),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (rd_ptr),
    .rd_data (mem_rdata)
);

endmodule // asqr_top

// ==== test/asqr_checker.sv ====
// Port assertions of the responder top
`timescale 1ns/1ps
`include "asqr_defs.vh"
module asqr_checker (
    input wire                    pclk,
    input wire                    presetn,
    input wire [`ASQR_ADDR_W-1:0] paddr,
    input wire                    psel,
    input wire                    penable,
    input wire                    pwrite,
    input wire [`ASQR_DATA_W-1:0] prdata,
    input wire                    pready,
    input wire                    pslverr,
    input wire [`ASQR_AXES-1:0]   limit_pin,
    input wire [`ASQR_AXES-1:0]   done_notify,
    input wire [`ASQR_AXES-1:0]   done_flags,
    input wire                    limit_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    rdy_latency_a: assert property (s_wait |=> pready)
        else $error("late ready");
    rdy_single_a: assert property (s_wait ##1 s_done |=> !pready)
        else $error("ready too long");
    rdy_in_access_a: assert property (pready |-> psel && penable)
        else $error("stray ready");
    err_decode_a: assert property (s_done |-> pslverr == (paddr > `ASQR_DATA_ADDR))
        else $error("bad error response");
    cmd_read_zero_a: assert property (psel && penable && pready && !pwrite &&
        paddr == `ASQR_CMD_ADDR |-> prdata == 0)
        else $error("command read not zero");
    done_set_a: assert property (done_notify != 0 |=> (done_flags & $past(done_notify)) != 0)
        else $error("done flag not set");
    done_source_a: assert property (|(done_flags & ~$past(done_flags)) |-> |$past(done_notify))
        else $error("done flag rose alone");
    lim_clear_a: assert property ($fell(limit_flag) |-> $countones(limit_pin) <= 1)
        else $error("limit flag cleared early");
endmodule // asqr_checker

bind asqr_top asqr_checker i_asqr_checker (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .limit_pin, .done_notify, .done_flags, .limit_flag);

// ==== test/asqr_host.sv ====
// Host model: bus master that issues commands and collects replies
`timescale 1ns/1ps
`include "asqr_defs.vh"
module asqr_host (
    input  wire        pclk,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [7:0]  paddr,
    output reg  [31:0] pwdata
);
    reg err;
    initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        // Released lines show the inverse
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
    endtask
    task reply(input [3:0] op, output string s);
        reg [31:0] q;
        integer    n;
        xfer(`ASQR_CMD_ADDR, 1'b1, {28'h0, op}, q);
        n = 0;
        q = 32'h1;
        while (q[`ASQR_ST_BUSY] && n < 300) begin
            xfer(`ASQR_STAT_ADDR, 1'b0, 32'h0, q);
            n = n + 1;
        end
        s = "";
        for (n = q[13:8]; n > 0; n = n - 1) begin
            xfer(`ASQR_DATA_ADDR, 1'b0, 32'h0, q);
            s = {s, string'(q[7:0])};
        end
    endtask
endmodule // asqr_host

// ==== test/tb_top.sv ====
// Self-checking bench of the axis status query responder
`timescale 1ns/1ps
`include "asqr_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
    reg          pclk, presetn, cont, fjog;
    reg  [3:0]   lim, home, neg, dn, stop;
    reg  [127:0] acc_s, acc_l, vel, pos;
    wire [31:0]  prdata, pwdata;
    wire [7:0]   paddr;
    wire         psel, penable, pwrite, pready, pslverr, limit_flag;
    wire [3:0]   done_flags;
    reg  [31:0]  q;
    string       s, e;
    integer      error_cnt = 0, cmp_count = 0, cyc = 0;
    localparam string F = "\n\r\r";
    asqr_top i_asqr_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .limit_pin(lim), .home_pin(home), .axis_dir_neg(neg), .done_notify(dn),
        .axis_stopped(stop), .axis_at_speed(~stop), .contour_active(cont), .fractional_jog(fjog),
        .accel_start(acc_s), .accel_end(acc_l), .accel_now(128'h0), .accel_lead_in(acc_l),
        .velocity(vel), .user_position(pos), .done_flags, .limit_flag);
    asqr_host u_host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            results;
        end
    end
    function string fld(input integer i, input d);
        fld = {neg[i] ? "M" : "P", d ? "D" : "N", lim[i] ? "L" : "N", home[i] ? "H" : "N"};
    endfunction
    task pulse(input [3:0] m);
        @(posedge pclk);
        dn <= m;
        @(posedge pclk);
        dn <= 4'h0;
        repeat (5) @(posedge pclk);
    endtask
    task cmd(input [3:0] op, input string x, input string n);
        u_host.reply(op, s);
        `CHK(n, 1'b1, s == x)
    endtask
    task t_regs;
        u_host.xfer(`ASQR_STAT_ADDR, 1'b0, 32'h0, q);
        `CHK("status", 32'h0, q)
        u_host.xfer(8'h40, 1'b0, 32'h0, q);
        `CHK("unmapped", 33'h100000000, {u_host.err, q})
        $display("t_regs done");
    endtask
    task t_axis;
        lim <= 4'h2;
        home <= 4'h2;
        pulse(4'h2);
        u_host.xfer(`ASQR_CTRL_ADDR, 1'b1, 32'h2, q);
        cmd(`ASQR_OP_AXIS_QRY, {F, fld(1, 1), F}, "query");
        `CHK("query flags", 5'h12, {limit_flag, done_flags})
        cmd(`ASQR_OP_AXIS_CLR, {F, fld(1, 1), F}, "request");
        `CHK("request flags", 5'h00, {limit_flag, done_flags})
        lim <= 4'h6;
        neg <= 4'h2;
        pulse(4'h0);
        cmd(`ASQR_OP_AXIS_CLR, {F, "MNLH", F}, "minus");
        `CHK("limit kept", 1'b1, limit_flag)
        $display("t_axis done");
    endtask
    task t_all;
        pulse(4'h9);
        u_host.xfer(`ASQR_CTRL_ADDR, 1'b1, 32'h1, q);
        cmd(`ASQR_OP_AXIS_CLR, "", "refused");
        `CHK("refused flags", 4'h9, done_flags)
        e = {F, fld(0, 1), ",", fld(1, 0), ",", fld(2, 0), ",", fld(3, 1), F};
        cmd(`ASQR_OP_ALL_QRY, e, "all query");
        `CHK("all query flags", 4'h9, done_flags)
        cmd(`ASQR_OP_ALL_CLR, e, "all request");
        `CHK("all request flags", 4'h0, done_flags)
        $display("t_all done");
    endtask
    task t_num;
        cont <= 1'b1;
        cmd(`ASQR_OP_ACCEL, "\n\r5,6,7,8\n\r", "lead in");
        cont <= 1'b0;
        u_host.xfer(`ASQR_CTRL_ADDR, 1'b1, 32'h0, q);
        cmd(`ASQR_OP_ACCEL, "\n\r2000000\n\r", "accel");
        stop <= 4'h0;
        cmd(`ASQR_OP_ACCEL, "\n\r5\n\r", "at speed");
        fjog <= 1'b1;
        cmd(`ASQR_OP_VEL, "\n\r12345\n\r", "jog vel");
        fjog <= 1'b0;
        cmd(`ASQR_OP_VEL, "\n\r12346\n\r", "vel");
        cmd(`ASQR_OP_UPOS, "\n\r3.50000\n\r", "position");
        $display("t_num done");
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {presetn, lim, home, neg, dn, stop, cont, fjog} = {1'b0, 16'h0, 4'hf, 2'b00};
        acc_s = {96'h0, 32'h001e8480};
        acc_l = {32'h8, 32'h7, 32'h6, 32'h5};
        vel = {96'h0, 32'h003039c0};
        pos = {96'h0, 32'h00055730};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_axis;
        t_all;
        t_num;
        results;
    end
endmodule // tb_top
